/* File: flash_host_pkg.sv */
// Constants shared by the flash command host controller and its helpers.
// Assumes a parallel NOR flash with 16-bit data and 16 address lines on the far side.
`default_nettype none
package flash_host_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;

	// Command addresses on the low address lines.
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR_1 = 16'h0555;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR_2 = 16'h02aa;
	localparam logic [ADDR_W-1:0] ANY_ADDR      = 16'h0000;

	// Command data codes on the low data byte.
	localparam logic [DATA_W-1:0] CODE_UNLOCK_1 = 16'h00aa;
	localparam logic [DATA_W-1:0] CODE_UNLOCK_2 = 16'h0055;
	localparam logic [DATA_W-1:0] CODE_RESET    = 16'h00f0;
	localparam logic [DATA_W-1:0] CODE_IDENT    = 16'h0090;
	localparam logic [DATA_W-1:0] CODE_PROGRAM  = 16'h00a0;
	localparam logic [DATA_W-1:0] CODE_BYPASS   = 16'h0020;
	localparam logic [DATA_W-1:0] CODE_BYP_EXIT = 16'h0000;
	localparam logic [DATA_W-1:0] CODE_ERASE    = 16'h0080;
	localparam logic [DATA_W-1:0] CODE_CHIP     = 16'h0010;
	localparam logic [DATA_W-1:0] CODE_BLOCK    = 16'h0030;
	localparam logic [DATA_W-1:0] CODE_SUSPEND  = 16'h00b0;
	localparam logic [DATA_W-1:0] CODE_RESUME   = 16'h0030;

	// Status byte bit positions.
	localparam int POLLING_BIT          = 7;
	localparam int MAIN_TOGGLE_BIT      = 6;
	localparam int FAILURE_BIT          = 5;
	localparam int ERASE_TIMER_BIT      = 3;
	localparam int SECONDARY_TOGGLE_BIT = 2;

	// User commands.
	typedef enum logic [3:0] {
		CMD_RESET       = 4'h0,
		CMD_IDENT       = 4'h1,
		CMD_PROGRAM     = 4'h2,
		CMD_BYPASS_IN   = 4'h3,
		CMD_BYPASS_PROG = 4'h4,
		CMD_BYPASS_OUT  = 4'h5,
		CMD_CHIP_ERASE  = 4'h6,
		CMD_BLOCK_ERASE = 4'h7,
		CMD_BLOCK_ADD   = 4'h8,
		CMD_SUSPEND     = 4'h9,
		CMD_RESUME      = 4'ha,
		CMD_READ        = 4'hb
	} cmd_t;

	// Result codes.
	localparam logic [1:0] RES_OK      = 2'h0;
	localparam logic [1:0] RES_FAIL    = 2'h1;
	localparam logic [1:0] RES_TIMEOUT = 2'h2;

	// Bus cycle timing at 250 MHz.
	localparam int CLK_NS        = 4;
	localparam int SETUP_NS      = 40;
	localparam int STROBE_NS     = 40;
	localparam int HOLD_NS       = 20;
	localparam int SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC      = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PHASE_W       = 8;

	// Block erase selection window and suspend latency.
	localparam int ERASE_WINDOW_US = 50;
	localparam int SUSPEND_MAX_US  = 15;
	localparam int ERASE_WINDOW_CYC = ERASE_WINDOW_US * 1000 / CLK_NS;
	localparam int SUSPEND_MAX_CYC  = SUSPEND_MAX_US * 1000 / CLK_NS;
	localparam int WAIT_W          = 32;

	// Longest write sequence and step counter width.
	localparam int MAX_STEPS = 6;
	localparam int STEP_W    = 3;

endpackage : flash_host_pkg
`default_nettype wire

/* File: flash_seq_rom.sv */
// Small table of bus write steps for each flash command.
// Assumes a registered lookup; data appear one clock after cmd and step change.
`timescale 1ns/1ps
`default_nettype none
module flash_seq_rom (
	input  wire logic                             clk_sys_i,
	input  wire flash_host_pkg::cmd_t             cmd_i,
	input  wire logic [flash_host_pkg::STEP_W-1:0] step_i,
	input  wire logic [flash_host_pkg::ADDR_W-1:0] user_addr_i,
	input  wire logic [flash_host_pkg::DATA_W-1:0] user_data_i,
	output logic      [flash_host_pkg::ADDR_W-1:0] addr_o,
	output logic      [flash_host_pkg::DATA_W-1:0] data_o,
	output logic      [flash_host_pkg::STEP_W-1:0] len_o
);
	import flash_host_pkg::*;

	logic [ADDR_W-1:0] a_d;
	logic [DATA_W-1:0] d_d;
	logic [STEP_W-1:0] l_d;
	logic              unlock_step;

	always_comb begin
		unlock_step = (step_i == 3'd0) || (step_i == 3'd3);
		a_d = unlock_step ? UNLOCK_ADDR_1 : UNLOCK_ADDR_2;
		d_d = unlock_step ? CODE_UNLOCK_1 : CODE_UNLOCK_2;
		l_d = 3'd3;
		case (cmd_i)
			CMD_RESET: begin
				l_d = 3'd1;
				a_d = ANY_ADDR;
				d_d = CODE_RESET;
			end
			CMD_IDENT, CMD_BYPASS_IN: begin
				if (step_i == 3'd2) begin
					a_d = UNLOCK_ADDR_1;
					d_d = (cmd_i == CMD_IDENT) ? CODE_IDENT : CODE_BYPASS;
				end
			end
			CMD_PROGRAM: begin
				l_d = 3'd4;
				if (step_i == 3'd2) begin
					a_d = UNLOCK_ADDR_1;
					d_d = CODE_PROGRAM;
				end else if (step_i == 3'd3) begin
					a_d = user_addr_i;
					d_d = user_data_i;
				end
			end
			CMD_BYPASS_PROG, CMD_BYPASS_OUT: begin
				l_d = 3'd2;
				if (step_i == 3'd0) begin
					a_d = ANY_ADDR;
					d_d = (cmd_i == CMD_BYPASS_PROG) ? CODE_PROGRAM : CODE_IDENT;
				end else begin
					a_d = (cmd_i == CMD_BYPASS_PROG) ? user_addr_i : ANY_ADDR;
					d_d = (cmd_i == CMD_BYPASS_PROG) ? user_data_i : CODE_BYP_EXIT;
				end
			end
			CMD_CHIP_ERASE, CMD_BLOCK_ERASE: begin
				l_d = 3'd6;
				if (step_i == 3'd2) begin
					a_d = UNLOCK_ADDR_1;
					d_d = CODE_ERASE;
				end else if (step_i == 3'd5) begin
					a_d = (cmd_i == CMD_CHIP_ERASE) ? UNLOCK_ADDR_1 : user_addr_i;
					d_d = (cmd_i == CMD_CHIP_ERASE) ? CODE_CHIP : CODE_BLOCK;
				end
			end
			CMD_BLOCK_ADD: begin
				l_d = 3'd1;
				a_d = user_addr_i;
				d_d = CODE_BLOCK;
			end
			CMD_SUSPEND, CMD_RESUME: begin
				l_d = 3'd1;
				a_d = ANY_ADDR;
				d_d = (cmd_i == CMD_SUSPEND) ? CODE_SUSPEND : CODE_RESUME;
			end
			default: begin
				l_d = 3'd0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		addr_o <= a_d;
		data_o <= d_d;
		len_o  <= l_d;
	end

endmodule : flash_seq_rom
`default_nettype wire

/* File: flash_command_status.sv */
// Host controller that issues command sequences to a parallel NOR flash and polls its status byte.
// Assumes the flash pins are wired directly; data pins are two-way with active-low output enable.
`timescale 1ns/1ps
`default_nettype none
module flash_command_status #(
	parameter int ERASE_WINDOW_P = flash_host_pkg::ERASE_WINDOW_CYC,
	parameter int SUSPEND_MAX_P  = flash_host_pkg::SUSPEND_MAX_CYC
) (
	input  wire logic                              clk_sys_i,
	input  wire logic                              resetn_i,
	input  wire logic                              cmd_valid_i,
	input  wire flash_host_pkg::cmd_t              cmd_i,
	input  wire logic [flash_host_pkg::ADDR_W-1:0] cmd_addr_i,
	input  wire logic [flash_host_pkg::DATA_W-1:0] cmd_data_i,
	output logic                                   cmd_ready_o,
	output logic                                   done_o,
	output logic      [1:0]                        result_o,
	output logic      [flash_host_pkg::DATA_W-1:0] read_data_o,
	output logic      [7:0]                        last_status_o,
	output logic                                   error_lock_o,
	output logic      [flash_host_pkg::ADDR_W-1:0] flash_addr_o,
	output logic      [flash_host_pkg::DATA_W-1:0] flash_dq_o,
	output logic                                   flash_dq_oe_n_o,
	input  wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_i,
	output logic                                   flash_ce_n_o,
	output logic                                   flash_oe_n_o,
	output logic                                   flash_we_n_o
);
	import flash_host_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0000,
		ST_LOOKUP = 4'b0001,
		ST_WSETUP = 4'b0010,
		ST_WPULSE = 4'b0011,
		ST_WHOLD  = 4'b0100,
		ST_RSETUP = 4'b0101,
		ST_RPULSE = 4'b0110,
		ST_RHOLD  = 4'b0111,
		ST_EVAL   = 4'b1000,
		ST_FINISH = 4'b1001
	} state_t;

	state_t            state_q;
	cmd_t              cmd_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] data_q;
	logic [STEP_W-1:0] step_q;
	logic [PHASE_W-1:0] phase_q;
	logic [WAIT_W-1:0] wait_q;
	logic [7:0]        prev_q;
	logic              have_prev_q;
	logic [1:0]        res_q;
	logic [ADDR_W-1:0] rom_addr;
	logic [DATA_W-1:0] rom_data;
	logic [STEP_W-1:0] rom_len;
	logic [7:0]        rd_byte;
	logic              toggled;
	logic              polls;

	flash_seq_rom u_rom (
		.clk_sys_i   (clk_sys_i),
		.cmd_i       (cmd_q),
		.step_i      (step_q),
		.user_addr_i (addr_q),
		.user_data_i (data_q),
		.addr_o      (rom_addr),
		.data_o      (rom_data),
		.len_o       (rom_len)
	);

	// Reads go only to the low byte for status; unspecified bits are ignored.
	assign rd_byte = flash_dq_i[7:0];
	assign toggled = rd_byte[MAIN_TOGGLE_BIT] != prev_q[MAIN_TOGGLE_BIT];
	assign polls   = (cmd_q == CMD_PROGRAM) || (cmd_q == CMD_BYPASS_PROG) || (cmd_q == CMD_CHIP_ERASE)
		|| (cmd_q == CMD_RESUME);

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			state_q     <= ST_IDLE;
			cmd_q       <= CMD_READ;
			addr_q      <= '0;
			data_q      <= '0;
			step_q      <= '0;
			phase_q     <= '0;
			wait_q      <= '0;
			prev_q      <= 8'h00;
			have_prev_q <= 1'b0;
			res_q       <= RES_OK;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (cmd_valid_i) begin
						cmd_q       <= cmd_i;
						addr_q      <= cmd_addr_i;
						data_q      <= cmd_data_i;
						step_q      <= '0;
						have_prev_q <= 1'b0;
						wait_q      <= '0;
						res_q       <= RES_OK;
						// While locked by a failure only a reset may go out.
						if (error_lock_o && cmd_i != CMD_RESET) begin
							res_q   <= RES_FAIL;
							state_q <= ST_FINISH;
						end else if (cmd_i == CMD_READ) begin
							state_q <= ST_RSETUP;
						end else begin
							state_q <= ST_LOOKUP;
						end
					end
				end
				ST_LOOKUP: begin
					state_q <= ST_WSETUP;
					phase_q <= '0;
				end
				ST_WSETUP: begin
					phase_q <= phase_q + 8'd1;
					if (phase_q == PHASE_W'(SETUP_CYC - 1)) begin
						phase_q <= '0;
						state_q <= ST_WPULSE;
					end
				end
				ST_WPULSE: begin
					phase_q <= phase_q + 8'd1;
					if (phase_q == PHASE_W'(STROBE_CYC - 1)) begin
						phase_q <= '0;
						state_q <= ST_WHOLD;
					end
				end
				ST_WHOLD: begin
					phase_q <= phase_q + 8'd1;
					if (phase_q == PHASE_W'(HOLD_CYC - 1)) begin
						phase_q <= '0;
						if (step_q + 3'd1 < rom_len) begin
							step_q  <= step_q + 3'd1;
							state_q <= ST_LOOKUP;
						end else if (polls) begin
							state_q <= ST_RSETUP;
						end else begin
							state_q <= ST_FINISH;
						end
					end
				end
				ST_RSETUP: begin
					phase_q <= phase_q + 8'd1;
					if (phase_q == PHASE_W'(SETUP_CYC - 1)) begin
						phase_q <= '0;
						state_q <= ST_RPULSE;
					end
				end
				ST_RPULSE: begin
					phase_q <= phase_q + 8'd1;
					if (phase_q == PHASE_W'(STROBE_CYC - 1)) begin
						phase_q <= '0;
						state_q <= ST_RHOLD;
					end
				end
				ST_RHOLD: begin
					phase_q <= phase_q + 8'd1;
					if (phase_q == PHASE_W'(HOLD_CYC - 1)) begin
						phase_q <= '0;
						state_q <= (cmd_q == CMD_READ) ? ST_FINISH : ST_EVAL;
					end
				end
				ST_EVAL: begin
					// Toggle polling: two reads with equal toggle bit mean the controller is idle.
					have_prev_q <= 1'b1;
					prev_q      <= rd_byte;
					wait_q      <= wait_q + 32'd1;
					if (have_prev_q && !toggled) begin
						res_q   <= RES_OK;
						state_q <= ST_FINISH;
					end else if (have_prev_q && res_q == RES_FAIL) begin
						// Still toggling on the read after the failure bit: the operation failed.
						state_q <= ST_FINISH;
					end else if (have_prev_q && rd_byte[FAILURE_BIT]) begin
						// Array data may show bit five as the controller returns, so a re-read confirms it.
						res_q   <= RES_FAIL;
						state_q <= ST_RSETUP;
					end else if (wait_q >= 32'(ERASE_WINDOW_P + SUSPEND_MAX_P)) begin
						// Bounds the polling so that a stuck device cannot hang the user port.
						res_q   <= RES_TIMEOUT;
						state_q <= ST_FINISH;
					end else begin
						state_q <= ST_RSETUP;
					end
				end
				ST_FINISH: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Bus pin drive, all registered.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			flash_ce_n_o    <= 1'b1;
			flash_oe_n_o    <= 1'b1;
			flash_we_n_o    <= 1'b1;
			flash_dq_oe_n_o <= 1'b1;
			flash_addr_o    <= '0;
			flash_dq_o      <= '0;
		end else begin
			flash_ce_n_o    <= !(state_q inside {ST_WSETUP, ST_WPULSE, ST_WHOLD, ST_RSETUP, ST_RPULSE, ST_RHOLD});
			flash_we_n_o    <= !(state_q == ST_WPULSE);
			flash_oe_n_o    <= !(state_q inside {ST_RPULSE, ST_RHOLD});
			flash_dq_oe_n_o <= !(state_q inside {ST_WSETUP, ST_WPULSE, ST_WHOLD});
			if (state_q == ST_WSETUP) begin
				flash_addr_o <= rom_addr;
				flash_dq_o   <= rom_data;
			end else if (state_q == ST_RSETUP) begin
				flash_addr_o <= addr_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// User answers and the failure lock.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			cmd_ready_o   <= 1'b0;
			done_o        <= 1'b0;
			result_o      <= RES_OK;
			read_data_o   <= '0;
			last_status_o <= 8'h00;
			error_lock_o  <= 1'b0;
		end else begin
			cmd_ready_o <= (state_q == ST_IDLE) && !cmd_valid_i;
			done_o      <= (state_q == ST_FINISH);
			if (state_q == ST_FINISH) begin
				result_o <= res_q;
			end
			if (state_q == ST_RHOLD && phase_q == PHASE_W'(HOLD_CYC - 1)) begin
				read_data_o   <= flash_dq_i;
				last_status_o <= rd_byte;
			end
			if (state_q == ST_FINISH && res_q == RES_FAIL && cmd_q != CMD_RESET && !error_lock_o) begin
				error_lock_o <= 1'b1;
			end else if (state_q == ST_FINISH && cmd_q == CMD_RESET) begin
				error_lock_o <= 1'b0;
			end
		end
	end

endmodule : flash_command_status
`default_nettype wire

/* File: flash_command_status_properties.sv */
// Assertions on the host controller's user handshake and flash strobes.
// Assumes it is bound into flash_command_status and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module flash_command_status_properties #(
	parameter int ERASE_WINDOW_P = 16,
	parameter int SUSPEND_MAX_P = 8
) (
	input wire logic			clk_sys_i,
	input wire logic			resetn_i,
	input wire logic			cmd_valid_i,
	input wire flash_host_pkg::cmd_t	cmd_i,
	input wire logic			cmd_ready_o,
	input wire logic			done_o,
	input wire logic [1:0]		result_o,
	input wire logic			error_lock_o,
	input wire logic [15:0]		flash_addr_o,
	input wire logic [15:0]		flash_dq_o,
	input wire logic			flash_dq_oe_n_o,
	input wire logic			flash_ce_n_o,
	input wire logic			flash_oe_n_o,
	input wire logic			flash_we_n_o
);
	import flash_host_pkg::*;
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);
	////////////////////////
	// A refused request must finish soon and never strobe a write.
	sequence s_locked_req;
		cmd_ready_o && cmd_valid_i && error_lock_o && cmd_i != CMD_RESET;
	endsequence
	sequence s_refused;
		flash_we_n_o throughout (##[1:60] (done_o && result_o == RES_FAIL));
	endsequence
	sequence s_strobe;
		(!flash_we_n_o) [*8];
	endsequence
	chk_write_drive: assert property (!flash_we_n_o |-> !flash_ce_n_o && !flash_dq_oe_n_o)
		else $error("write strobe without select or data");
	chk_read_release: assert property (!flash_oe_n_o |-> flash_dq_oe_n_o && flash_we_n_o && !flash_ce_n_o)
		else $error("read strobe while driving data");
	chk_strobe_width: assert property ($fell(flash_we_n_o) |-> s_strobe)
		else $error("write strobe too short");
	chk_write_hold: assert property (!flash_we_n_o && !$past(flash_we_n_o) |-> $stable({flash_addr_o, flash_dq_o}))
		else $error("address or data moved in write strobe");
	chk_done_pulse: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
	chk_take_req: assert property (cmd_ready_o && cmd_valid_i |=> !cmd_ready_o)
		else $error("request not taken");
	chk_idle_bus: assert property (cmd_ready_o |-> flash_we_n_o && flash_oe_n_o)
		else $error("bus active while idle");
	chk_lock_refuse: assert property (s_locked_req |-> s_refused)
		else $error("locked request reached the bus");
	chk_lock_fail: assert property (done_o && result_o == RES_FAIL |-> ##[0:2] error_lock_o)
		else $error("failure without lock");
endmodule : flash_command_status_properties
`default_nettype wire

/* File: flash_device_model.sv */
// Behavioural parallel flash: command decoder, array and status byte.
// Assumes one host; busy time is counted in status reads, not in time.
`timescale 1ns/1ps
`default_nettype none
module flash_device_model #(
	parameter logic [15:0] IDENT_CODE = 16'h5a3c // Arbitrary value.
) (
	input wire logic [15:0]	addr_i,
	input wire logic [15:0]	dq_i,
	input wire logic		ce_n_i,
	input wire logic		oe_n_i,
	input wire logic		we_n_i,
	input wire logic		fail_i,
	output logic [15:0]		dq_o
);
	logic [15:0] mem [logic [15:0]];
	logic [15:0] pa, pd, q[$];
	logic [15:0] last = '0;
	logic blk [16];
	logic byp = 0, idm = 0, er = 0, sus = 0, et = 0, tg = 0, tg2 = 0, f = 0;
	int st = 0, busy = 0;
	function automatic logic [15:0] rd(logic [15:0] a);
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction : rd
	// A released bus shows the inverse of the last word, so a stale value never passes.
	assign dq_o = (!ce_n_i && !oe_n_i) ? last : ~last;
	////////////////////////
	always @(posedge we_n_i) if (!ce_n_i) begin : wr
		logic [10:0] a;
		logic [7:0] d;
		a = addr_i[10:0];
		d = dq_i[7:0];
		if (f) begin
			// A reset after a failure abandons the failed operation.
			if (d == 8'hf0) begin
				f = 0;
				er = 0;
				busy = 0;
			end
		end else if (busy > 0 && !sus) begin
			if (er && d == 8'hb0) sus = 1;
			if (er && !et && d == 8'h30) busy = 6;
			if (er && !et && d == 8'h30) blk[addr_i[15:12]] = 1;
		end else if (sus && st == 0 && d == 8'h30) sus = 0;
		else if (d == 8'hf0 && !byp) begin
			st = 0;
			idm = 0;
		end else case (st)
			0: st = byp ? (d == 8'ha0 ? 3 : d == 8'h90 ? 7 : 0) : int'(a == 11'h555 && d == 8'haa);
			1: st = (a == 11'h2aa && d == 8'h55) ? 2 : 0;
			2: begin
				st = (a == 11'h555 && d == 8'ha0) ? 3 : (a == 11'h555 && d == 8'h80) ? 4 : 0;
				if (a == 11'h555 && d == 8'h90) idm = 1;
				if (a == 11'h555 && d == 8'h20) byp = 1;
			end
			3: begin
				st = 0;
				pa = addr_i;
				pd = dq_i;
				er = 0;
				if (fail_i) f = 1;
				else busy = 4;
			end
			4: st = (a == 11'h555 && d == 8'haa) ? 5 : 0;
			5: st = (a == 11'h2aa && d == 8'h55) ? 6 : 0;
			6: begin
				st = 0;
				blk = '{default: 0};
				if (d == 8'h30) blk[addr_i[15:12]] = 1;
				else if (a == 11'h555 && d == 8'h10) blk = '{default: 1};
				er = blk[addr_i[15:12]];
				et = d == 8'h10;
				busy = er ? 6 : 0;
				if (fail_i && er) f = 1;
			end
			7: begin
				st = 0;
				if (d == 8'h00) byp = 0;
			end
			default: st = 0;
		endcase
	end
	always @(negedge oe_n_i) if (!ce_n_i) begin : rdp
		if (f || (busy > 0 && !(sus && !blk[addr_i[15:12]]))) begin
			if (!sus) tg = ~tg;
			if (er && blk[addr_i[15:12]]) tg2 = ~tg2;
			last = {8'h00, er ? sus : ~pd[7], tg, f, 1'b0, et, tg2, 2'b00};
			if (!sus && !f) busy = busy - 1;
			if (er && busy < 4) et = 1;
			if (busy == 0 && !f && !er) mem[pa] = rd(pa) & pd;
			if (busy == 0 && !f && er) begin
				q = {};
				foreach (mem[k]) if (blk[k[15:12]]) q.push_back(k);
				foreach (q[i]) mem.delete(q[i]);
				er = 0;
			end
		end else last = idm ? (addr_i[1:0] == 2'b00 ? IDENT_CODE : 16'h0000) : rd(addr_i);
	end
endmodule : flash_device_model
`default_nettype wire

/* File: flash_command_status_test.sv */
// Self-checking bench for the flash host controller against a behavioural flash.
// Assumes the package, design, flash model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module flash_command_status_test;
	import flash_host_pkg::*;
	localparam logic [15:0] ID_CODE = 16'h5a3c; // Arbitrary value.
	logic clk_sys_i, resetn_i, cmd_valid_i, fail_i, cmd_ready_o, done_o, error_lock_o;
	logic flash_dq_oe_n_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o;
	cmd_t cmd_i;
	logic [15:0] cmd_addr_i, cmd_data_i, read_data_o, flash_addr_o, flash_dq_o, flash_dq_i, mdl_dq, a, d;
	logic [15:0] ref_mem [logic [15:0]];
	logic [7:0] last_status_o, s;
	logic [1:0] result_o;
	int fail_count = 0;
	int num_checks = 0;
	// The data wire carries whichever side has its driver enabled.
	assign flash_dq_i = !flash_dq_oe_n_o ? flash_dq_o : mdl_dq;
	flash_command_status #(.ERASE_WINDOW_P(16), .SUSPEND_MAX_P(8)) dut (.*);
	flash_device_model #(.IDENT_CODE(ID_CODE)) mdl (.addr_i(flash_addr_o), .dq_i(flash_dq_i),
		.ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o), .fail_i(fail_i), .dq_o(mdl_dq));
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	////////////////////////
	function automatic logic [15:0] ref_rd(logic [15:0] k);
		return ref_mem.exists(k) ? ref_mem[k] : 16'hffff;
	endfunction : ref_rd
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic run(input cmd_t c, input logic [15:0] ad, input logic [15:0] dt, input logic [1:0] er);
		int n;
		n = 0;
		while (cmd_ready_o !== 1'b1) begin
			@(posedge clk_sys_i);
			#1;
		end
		@(posedge clk_sys_i);
		cmd_valid_i <= 1'b1;
		cmd_i <= c;
		cmd_addr_i <= ad;
		cmd_data_i <= dt;
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
			if (cmd_ready_o !== 1'b1) cmd_valid_i <= 1'b0;
		end while (done_o !== 1'b1 && n < 3000);
		if (n >= 3000) fail_count++;
		chk({14'h0, result_o}, {14'h0, er});
	endtask : run
	task automatic rdc(input logic [15:0] ad, input logic [15:0] e);
		run(CMD_READ, ad, 16'h0, RES_OK);
		chk(read_data_o, e);
	endtask : rdc
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report
	initial begin
		#200000;
		fail_count++;
		final_report();
	end
	initial begin
		{resetn_i, cmd_valid_i, fail_i} = 3'b000;
		cmd_i = CMD_READ;
		cmd_addr_i = 16'h0;
		cmd_data_i = 16'h0;
		void'($urandom(25));
		repeat (5) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk({12'h0, cmd_ready_o, flash_we_n_o, flash_oe_n_o, flash_ce_n_o}, 16'hf);
		$display("test reset done");
		a = {4'h4, 12'($urandom)};
		d = 16'($urandom);
		run(CMD_PROGRAM, a, d, RES_OK);
		ref_mem[a] = d;
		rdc(a, ref_rd(a));
		d = 16'($urandom);
		run(CMD_PROGRAM, a, d, RES_OK);
		ref_mem[a] = ref_rd(a) & d;
		rdc(a, ref_rd(a));
		$display("test program done");
		run(CMD_BYPASS_IN, 16'h0, 16'h0, RES_OK);
		for (int i = 1; i < 4; i++) begin
			d = 16'($urandom);
			run(CMD_BYPASS_PROG, a + 16'(i), d, RES_OK);
			ref_mem[a + 16'(i)] = d;
		end
		run(CMD_BYPASS_OUT, 16'h0, 16'h0, RES_OK);
		for (int i = 0; i < 4; i++) rdc(a + 16'(i), ref_rd(a + 16'(i)));
		$display("test bypass done");
		run(CMD_IDENT, 16'h0, 16'h0, RES_OK);
		rdc(16'h0, ID_CODE);
		run(CMD_RESET, 16'h0, 16'h0, RES_OK);
		rdc(a, ref_rd(a));
		$display("test ident done");
		run(CMD_BLOCK_ERASE, a, 16'h0, RES_OK);
		run(CMD_READ, a, 16'h0, RES_OK);
		chk({8'h0, last_status_o & 8'h88}, 16'h0);
		run(CMD_BLOCK_ADD, a ^ 16'h1000, 16'h0, RES_OK);
		run(CMD_SUSPEND, 16'h0, 16'h0, RES_OK);
		run(CMD_READ, a, 16'h0, RES_OK);
		s = last_status_o;
		chk({8'h0, s & 8'h80}, 16'h80);
		run(CMD_READ, a, 16'h0, RES_OK);
		chk({8'h0, (s ^ last_status_o) & 8'h44}, 16'h4);
		rdc(a ^ 16'h2000, 16'hffff);
		run(CMD_RESUME, 16'h0, 16'h0, RES_OK);
		ref_mem.delete();
		for (int i = 0; i < 4; i++) rdc(a + 16'(i), 16'hffff);
		$display("test block erase done");
		run(CMD_PROGRAM, a ^ 16'h2000, 16'($urandom), RES_OK);
		run(CMD_CHIP_ERASE, 16'h0, 16'h0, RES_OK);
		rdc(a ^ 16'h2000, 16'hffff);
		$display("test chip erase done");
		fail_i = 1'b1;
		run(CMD_BLOCK_ERASE, a, 16'h0, RES_OK);
		run(CMD_READ, a, 16'h0, RES_OK);
		s = last_status_o;
		chk({8'h0, s & 8'h20}, 16'h20);
		run(CMD_READ, a ^ 16'h2000, 16'h0, RES_OK);
		chk({8'h0, (s ^ last_status_o) & 8'h04}, 16'h0);
		run(CMD_READ, a, 16'h0, RES_OK);
		chk({8'h0, (s ^ last_status_o) & 8'h04}, 16'h4);
		run(CMD_RESET, 16'h0, 16'h0, RES_OK);
		run(CMD_PROGRAM, a, 16'($urandom), RES_FAIL);
		run(CMD_PROGRAM, a, 16'h0, RES_FAIL);
		chk({15'h0, error_lock_o}, 16'h1);
		fail_i = 1'b0;
		run(CMD_RESET, 16'h0, 16'h0, RES_OK);
		rdc(a, 16'hffff);
		chk({15'h0, error_lock_o}, 16'h0);
		$display("test failure done");
		final_report();
	end
endmodule : flash_command_status_test
bind flash_command_status flash_command_status_properties #(.ERASE_WINDOW_P(ERASE_WINDOW_P),
	.SUSPEND_MAX_P(SUSPEND_MAX_P)) props_i (.*);
`default_nettype wire
